// file: shared/sar_port_defs.svh
// Constants for the successive-approximation converter serial port.
`ifndef SAR_PORT_DEFS_SVH
`define SAR_PORT_DEFS_SVH
`define SAR_RESULT_W 16
`define SAR_EDGE_W 5
`define SAR_EDGE_LEAD 5'h02
`define SAR_EDGE_MSB 5'h03
`define SAR_EDGE_LAST 5'h12
`define SAR_POS_FULL 16'h7FFF
`define SAR_NEG_FULL 16'h8000
`define SAR_FIFO_DEPTH 16
`define SAR_SYNC_W 2
`endif

// file: shared/sar_port_pkg.sv
// Types shared by the converter serial port design.
`default_nettype none
`include "sar_port_defs.svh"
package sar_port_pkg;
    typedef enum logic [1:0] {
        zero_power_track_state,
        convert_state,
        done_state
    } phase_t;
endpackage : sar_port_pkg
`default_nettype wire

// file: design/sar_result_fifo.sv
// Small synchronous FIFO that holds converted results for the serial shifter.
`default_nettype none
module sar_result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign count = wr_ptr - rd_ptr;
    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + (AW+1)'(1);
            end
        end
    end
endmodule : sar_result_fifo
`default_nettype wire

// file: design/sar_serial_port.sv
// Digital sequencer and serial readout of a 16-bit differential SAR converter.
// How it works
// - On frame open the input difference is held; inputs stay off until conversion ends.
// - After each conversion window fall back to tracking; restart with no delay.
// - Track while chip select high, or low after the eighteenth falling clock edge.
// - Three wires: chip select, serial clock, data out; serial clock paces everything.
// - Chip select may rise mid-conversion; the device then stops that conversion.
// - Result leaves most significant bit first, one bit per serial clock.
// - Bits shifted in a frame belong to that frame's own conversion; here a frame sends the oldest code waiting in the FIFO.
// - Result is two's complement; top of range clamps to 7FFF.
// - Bottom of range clamps to 8000.
// - Output floats while chip select high and for the first clock period after.
// - Falling edge two gives a leading zero; edges three to eighteen give the result.
// - Chip select rising early abandons conversion and floats output.
//
// The analog array is outside this logic: sample_hold_o closes the input switches,
// and the converter's finished code arrives on adc_code_i with adc_code_valid_i.
// Codes wait in a FIFO so the shifter takes the oldest waiting code when it arrives before the third counted edge.
//
// Each pin passes two synchroniser stages and one edge-detect stage, so the
// outputs answer a pin change on the third system clock edge after it. The serial
// clock must therefore stay high and low for several system clocks each; a
// faster serial clock is simply not seen.
// A frame claims the oldest waiting code as it opens. That code must arrive
// before the third counted edge, or the shifter sends whatever it last held.
// Cutting a frame short throws its code away, so the next frame claims a new one.
// There is no minimum serial clock rate here; charge leakage is an analog
// limit that the controller has to respect.
`default_nettype none
`include "sar_port_defs.svh"
module sar_serial_port #(
    parameter int RESULT_W = `SAR_RESULT_W,
    parameter int FIFO_DEPTH = `SAR_FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    // Link pins, asynchronous to the system clock.
    input wire logic cs_n_i,
    input wire logic sclk_i,
    // Analog array side, on the system clock.
    input wire logic signed [RESULT_W:0] adc_code_i,
    input wire logic adc_code_valid_i,
    output logic adc_code_ready_o,
    // Controls back to the analog array.
    output logic sample_hold_o,
    output logic convert_step_o,
    output logic zero_power_track_o,
    // Serial data pin and its driver enable.
    output logic dout_o,
    output logic dout_oe_o
);
    ////////////////////////////////////////////////////////////////////////////

    // All registers of the port except ready_q and the FIFO live in this one record, so the reset value
    // and the next value are both written in one place.
    typedef struct packed {
        // Synchronisers and edge-detect history.
        logic [`SAR_SYNC_W-1:0] cs_sync;
        logic [`SAR_SYNC_W-1:0] sclk_sync;
        logic sclk_prev;
        logic cs_prev;
        // Frame sequencing.
        sar_port_pkg::phase_t phase;
        logic [`SAR_EDGE_W-1:0] edges;
        // Result shifter and its claim on a FIFO code.
        logic [RESULT_W-1:0] shift;
        logic have_code;
        // Registered outputs.
        logic sample_hold;
        logic convert_step;
        logic track;
        logic dout;
        logic dout_oe;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [RESULT_W-1:0] fifo_out_data;
    logic [RESULT_W-1:0] clamped;

    // The analog code is one bit wider so that overrange can be clamped here.
    function automatic logic [RESULT_W-1:0] clamp_code(input logic signed [RESULT_W:0] c);
        logic signed [RESULT_W:0] pos;
        logic signed [RESULT_W:0] neg;
        pos = $signed({1'b0, RESULT_W'(`SAR_POS_FULL)});
        neg = $signed({1'b1, RESULT_W'(`SAR_NEG_FULL)});
        if (c >= pos) begin
            clamp_code = RESULT_W'(`SAR_POS_FULL);
        end else if (c <= neg) begin
            clamp_code = RESULT_W'(`SAR_NEG_FULL);
        end else begin
            clamp_code = c[RESULT_W-1:0];
        end
    endfunction : clamp_code

    ////////////////////////////////////////////////////////////////////////////

    // A level that was high last cycle and is low now: one falling edge.
    function automatic logic fell_now(input logic prev_level, input logic level);
        fell_now = prev_level & ~level;
    endfunction : fell_now

    // Counted edges are always judged by the count they lead to, so every
    // decision of one falling edge sees the same number.
    function automatic logic [`SAR_EDGE_W-1:0] edge_after(
        input logic [`SAR_EDGE_W-1:0] e
    );
        edge_after = e + `SAR_EDGE_W'(1);
    endfunction : edge_after

    // The edge that turns the driver on and sends the leading zero.
    function automatic logic is_lead_edge(input logic [`SAR_EDGE_W-1:0] e);
        is_lead_edge = (edge_after(e) == `SAR_EDGE_LEAD);
    endfunction : is_lead_edge

    // Edges that carry a result bit, most significant first.
    function automatic logic is_data_edge(input logic [`SAR_EDGE_W-1:0] e);
        is_data_edge = (edge_after(e) >= `SAR_EDGE_MSB)
            && (edge_after(e) <= `SAR_EDGE_LAST);
    endfunction : is_data_edge

    // The edge that closes the conversion window and returns to tracking.
    function automatic logic is_last_edge(input logic [`SAR_EDGE_W-1:0] e);
        is_last_edge = (edge_after(e) == `SAR_EDGE_LAST);
    endfunction : is_last_edge

    assign clamped = clamp_code(adc_code_i);

    ////////////////////////////////////////////////////////////////////////////

    // Sixteen codes of slack let the analog side run ahead of a slow reader.
    // The ready output lags fullness by one cycle, so a producer that watches
    // only that port can lose one code when the FIFO fills; this is the price
    // of driving the port straight from a flip-flop.
    sar_result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(adc_code_valid_i),
        .in_ready_o(fifo_in_ready),
        .in_data_i(clamped),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////

    // Decoded pin events; cs_low is a level, each of the others is true for a single system clock cycle.
    logic cs_low;
    logic cs_fall;
    logic sclk_fall;
    logic frame_fall;

    always_comb begin
        // Only the second synchroniser stage and its delayed copy are read, so
        // a metastable first stage never reaches the decode below.
        cs_low = ~cur.cs_sync[1];
        cs_fall = fell_now(cur.cs_prev, cur.cs_sync[1]);
        sclk_fall = fell_now(cur.sclk_prev, cur.sclk_sync[1]);
        // A chip select that falls while the clock is low counts as the first edge.
        frame_fall = (cs_fall & ~cur.sclk_sync[1]) | (cs_low & ~cs_fall & sclk_fall);
        // Only take a code while converting; with no code waiting the frame sends the shifter's previous contents.
        fifo_out_ready = (cur.phase == sar_port_pkg::convert_state) && !cur.have_code;

        // Everything but the synchronisers and edge-detect history holds unless a branch below says otherwise; the step
        // output is a single-cycle pulse.
        next_cur = cur;
        next_cur.cs_sync = {cur.cs_sync[0], cs_n_i};
        next_cur.sclk_sync = {cur.sclk_sync[0], sclk_i};
        next_cur.cs_prev = cur.cs_sync[1];
        next_cur.sclk_prev = cur.sclk_sync[1];
        next_cur.convert_step = 1'b0;

        if (fifo_out_ready && fifo_out_valid) begin
            next_cur.shift = fifo_out_data;
            next_cur.have_code = 1'b1;
        end

        // Select high ends any frame at once: count, driver and code are dropped.
        if (!cs_low) begin
            next_cur.phase = sar_port_pkg::zero_power_track_state;
            next_cur.edges = '0;
            next_cur.dout_oe = 1'b0;
            next_cur.dout = 1'b0;
            next_cur.sample_hold = 1'b0;
            next_cur.track = 1'b1;
            next_cur.have_code = 1'b0;
        end else begin
            case (cur.phase)
                sar_port_pkg::zero_power_track_state: begin
                    // Leaving the tracking state costs no cycle: the array is
                    // switched to hold on the same edge that sees select fall.
                    if (cs_fall) begin
                        next_cur.phase = sar_port_pkg::convert_state;
                        next_cur.sample_hold = 1'b1;
                        next_cur.track = 1'b0;
                        // With the clock already low the select fall is itself
                        // the first counted edge; otherwise the first clock fall is.
                        if (frame_fall) begin
                            next_cur.edges = edge_after(cur.edges);
                            next_cur.convert_step = 1'b1;
                        end
                    end
                end
                sar_port_pkg::convert_state: begin
                    // Every counted falling edge is one conversion step and, from
                    // the second on, one bit on the data pin.
                    if (frame_fall) begin
                        next_cur.edges = edge_after(cur.edges);
                        next_cur.convert_step = 1'b1;
                        if (is_lead_edge(cur.edges)) begin
                            // The first counted period stays floating; the driver
                            // turns on here with a zero ahead of the result.
                            next_cur.dout_oe = 1'b1;
                            next_cur.dout = 1'b0;
                        end else if (is_data_edge(cur.edges)) begin
                            next_cur.dout = cur.shift[RESULT_W-1];
                            next_cur.shift = {cur.shift[RESULT_W-2:0], 1'b0};
                        end
                        if (is_last_edge(cur.edges)) begin
                            // The last bit stays on the pin while select is low;
                            // the array goes back to tracking at once.
                            next_cur.phase = sar_port_pkg::done_state;
                            next_cur.sample_hold = 1'b0;
                            next_cur.track = 1'b1;
                        end
                    end
                end
                sar_port_pkg::done_state: begin
                    // Further clock edges are ignored until select rises, so
                    // the count can never pass the last edge.
                    next_cur.track = 1'b1;
                end
                // An unused phase code falls back to tracking.
                default: begin
                    next_cur.phase = sar_port_pkg::zero_power_track_state;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            // The synchronisers start at the idle pin levels, so release of
            // reset never looks like a select fall or a clock edge.
            cur <= '{
                cs_sync: '1,
                sclk_sync: '0,
                sclk_prev: 1'b0,
                cs_prev: 1'b1,
                phase: sar_port_pkg::zero_power_track_state,
                edges: '0,
                shift: '0,
                have_code: 1'b0,
                sample_hold: 1'b0,
                convert_step: 1'b0,
                track: 1'b1,
                dout: 1'b0,
                dout_oe: 1'b0
            };
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Ready is registered so the port comes from a flip-flop like every other
    // output; it reads low during reset and rises one cycle after release.
    logic ready_q;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= fifo_in_ready;
        end
    end

    // Every output below is a register of the state record or ready_q.
    assign adc_code_ready_o = ready_q;
    assign sample_hold_o = cur.sample_hold;
    assign convert_step_o = cur.convert_step;
    assign zero_power_track_o = cur.track;
    assign dout_o = cur.dout;
    assign dout_oe_o = cur.dout_oe;
endmodule : sar_serial_port
`default_nettype wire

// file: test/sar_serial_port_asserts.sv
// Concurrent checks on the converter serial port pins.
`default_nettype none
module sar_serial_port_asserts #(
    parameter int RESULT_W = 16
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic signed [RESULT_W:0] adc_code_i,
    input wire logic adc_code_valid_i,
    input wire logic adc_code_ready_o,
    input wire logic sample_hold_o,
    input wire logic convert_step_o,
    input wire logic zero_power_track_o,
    input wire logic dout_o,
    input wire logic dout_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] steps;
    // Counts step pulses in the open frame; cleared once deselected and tracking.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            steps <= 5'h00;
        end else if (cs_n_i && zero_power_track_o) begin
            steps <= 5'h00;
        end else if (convert_step_o) begin
            steps <= steps + 5'h01;
        end
    end
    sequence idle_s;
        cs_n_i [*5];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    a_oe_idle: assert property (idle_s |-> !dout_oe_o)
        else $error("output driven while deselected");
    a_track_idle: assert property (idle_s |-> zero_power_track_o && !sample_hold_o)
        else $error("not tracking while deselected");
    a_hold_frame: assert property ($fell(cs_n_i) |-> ##[3:5] sample_hold_o)
        else $error("input not held at frame open");
    a_hold_excl: assert property (sample_hold_o |-> !zero_power_track_o)
        else $error("tracking while holding");
    a_oe_start: assert property ($rose(sample_hold_o) |-> !dout_oe_o)
        else $error("output driven in first period");
    a_lead_zero: assert property ($rose(dout_oe_o) |-> !dout_o)
        else $error("leading bit not zero");
    a_oe_drop: assert property ($rose(cs_n_i) |-> ##[3:5] !dout_oe_o)
        else $error("output not released after deselect");
    a_step_pulse: assert property (convert_step_o |=> !convert_step_o [*3])
        else $error("step pulse too long");
    a_step_cap: assert property (steps <= 5'h12)
        else $error("edges counted past the eighteenth");
    a_track_full: assert property ($rose(zero_power_track_o) && !cs_n_i
        |-> steps + 5'(convert_step_o) == 5'h12)
        else $error("tracking began at the wrong edge");
endmodule : sar_serial_port_asserts
bind sar_serial_port sar_serial_port_asserts #(.RESULT_W(RESULT_W)) chk (.mclk_i, .rst_i,
    .cs_n_i, .sclk_i, .adc_code_i, .adc_code_valid_i, .adc_code_ready_o, .sample_hold_o,
    .convert_step_o, .zero_power_track_o, .dout_o, .dout_oe_o);
`default_nettype wire

// file: test/sar_host_model.sv
// Behavioural host that frames conversions and reads the serial result.
`default_nettype none
module sar_host_model (
    input wire logic mclk_i,
    input wire logic dout_i,
    input wire logic dout_oe_i,
    output var logic cs_n_o,
    output var logic sclk_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // A released line shows the inverse, so a missing enable cannot pass as data.
    wire logic pin = dout_oe_i ? dout_i : ~dout_i;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end
    // The clock is low when select falls, so that fall is the first edge.
    task automatic frame(input int n, output logic [16:0] bits);
        bits = 17'h00000;
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
        for (int k = 2; k <= n + 1; k++) begin
            repeat (4) @(posedge mclk_i);
            sclk_o <= 1'b1;
            repeat (3) @(posedge mclk_i);
            @(negedge mclk_i);
            if (k > 2) bits = {bits[15:0], pin};
            @(posedge mclk_i);
            if (k <= n) sclk_o <= 1'b0;
        end
        cs_n_o <= 1'b1;
        @(posedge mclk_i);
        sclk_o <= 1'b0;
        repeat (24) @(posedge mclk_i);
    endtask : frame
endmodule : sar_host_model
`default_nettype wire

// file: test/sar_serial_port_test.sv
// Self-checking bench for the converter serial port.
`default_nettype none
module sar_serial_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic signed [16:0] adc_code_i = 17'h00000;
    logic adc_code_valid_i = 1'b0;
    wire cs_n_i, sclk_i, adc_code_ready_o, sample_hold_o, convert_step_o;
    wire zero_power_track_o, dout_o, dout_oe_o;
    int n_errors = 0;
    int cmp_count = 0;
    logic signed [16:0] codes [16];
    logic signed [16:0] edge_c [4] = '{17'h0FFFF, 17'h07FFF, 17'h18000, 17'h17FFF};
    always #12.5 mclk_i = ~mclk_i;
    sar_serial_port dut (.mclk_i, .rst_i, .cs_n_i, .sclk_i, .adc_code_i, .adc_code_valid_i,
        .adc_code_ready_o, .sample_hold_o, .convert_step_o, .zero_power_track_o, .dout_o,
        .dout_oe_o);
    sar_host_model host (.mclk_i, .dout_i(dout_o), .dout_oe_i(dout_oe_o), .cs_n_o(cs_n_i),
        .sclk_o(sclk_i));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] clamp(input logic signed [16:0] c);
        if (c > 17'sh07FFF) return 16'h7FFF;
        if (c < -17'sh08000) return 16'h8000;
        return c[15:0];
    endfunction : clamp
    task automatic fill_fifo;
        logic [15:0] v;
        for (int i = 0; i < 16; i++) begin
            v = 16'(i * 16'h2469);
            codes[i] = (i < 4) ? edge_c[i] : {v[15], v};
            @(posedge mclk_i);
            adc_code_i <= codes[i];
            adc_code_valid_i <= 1'b1;
            do @(negedge mclk_i); while (adc_code_ready_o !== 1'b1);
        end
        @(posedge mclk_i);
        adc_code_valid_i <= 1'b0;
        repeat (2) @(negedge mclk_i);
        check({16'h0000, adc_code_ready_o}, 17'h00000);
    endtask : fill_fifo
    // Frame five is cut short; its code is dropped and frame six takes the next one.
    task automatic drain_fifo;
        logic [16:0] bits;
        logic [15:0] e;
        for (int i = 0; i < 16; i++) begin
            e = clamp(codes[i]);
            host.frame((i == 5) ? 6 : 18, bits);
            if (i == 5) check(bits, {13'h0000, e[15:12]});
            else check(bits, {1'b0, e});
            check({16'h0000, dout_oe_o}, 17'h00000);
            check({16'h0000, zero_power_track_o}, 17'h00001);
        end
        check({16'h0000, adc_code_ready_o}, 17'h00001);
    endtask : drain_fifo
    task automatic summarize;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        fill_fifo();
        drain_fifo();
        summarize();
    end
    initial begin
        #300us;
        n_errors++;
        summarize();
    end
endmodule : sar_serial_port_test
`default_nettype wire
